// file: inc/apc_pkg.sv
// Package for the per-port status and control register bank.
package apc_pkg;
  // Number of ports and register map placement.
  localparam int NPORT = 4;
  localparam logic [3:0] OFF_HEC = 4'h3;
  localparam logic [3:0] OFF_CNT_LO = 4'h4;
  localparam logic [3:0] OFF_CNT_HI = 4'h5;
  localparam logic [3:0] OFF_CNT_SEL = 4'h6;
  localparam logic [3:0] OFF_MASK = 4'h7;
  localparam logic [3:0] OFF_CTRL1 = 4'h8;
  localparam logic [3:0] OFF_CTRL2 = 4'h9;
  localparam logic [3:0] OFF_IRQ_STAT = 4'ha;
  // Field positions in the HEC and activity register.
  localparam int B_RX_HEC_OFF = 6;
  localparam int B_TX_HEC_OFF = 5;
  localparam int B_MARK_HI = 4;
  localparam int B_MARK_LO = 3;
  localparam int B_TX_EMPTY = 2;
  localparam int B_TX_IDLE = 1;
  localparam int B_RX_IDLE = 0;
  // Counter selection bits.
  localparam int SEL_SYM = 3;
  localparam int SEL_TXC = 2;
  localparam int SEL_RXC = 1;
  localparam int SEL_HEC = 0;
  // Interrupt source bits, shared by status and mask.
  localparam int IRQ_HEC = 5;
  localparam int IRQ_SHORT = 4;
  localparam int IRQ_PAR = 3;
  localparam int IRQ_SIG = 2;
  localparam int IRQ_SYM = 1;
  localparam int IRQ_OVF = 0;
  localparam int NIRQ = 6;
  // Enhanced control fields.
  localparam int B_PORT_RST = 7;
  localparam int B_LOOP_TIME = 6;
  localparam int B_ID_SWAP = 5;
  localparam int B_ADDR_HI = 4;
  localparam int B_RATE_HI = 7;
  localparam int B_RATE_LO = 6;
  // Reset values.
  localparam logic [1:0] RST_MARK = 2'h0;
  localparam logic [1:0] RST_RATE = 2'h0;
  localparam logic [5:0] RST_MASK = 6'h00;
  localparam logic [15:0] RST_CNT = 16'h0000;
  // Timing marker widths in reference oscillator cycles.
  localparam logic [3:0] MARK_W0 = 4'h1;
  localparam logic [3:0] MARK_W1 = 4'h2;
  localparam logic [3:0] MARK_W2 = 4'h4;
  localparam logic [3:0] MARK_W3 = 4'h8;
  // Header check polynomial x^8+x^2+x+1 and its coset.
  localparam logic [7:0] HEC_POLY = 8'h07;
  localparam logic [7:0] HEC_COSET = 8'h55;
  // Interrupt events reported by one port's datapath.
  typedef struct packed {
    logic short_cell;
    logic tx_parity;
    logic sig_change;
    logic symbol_err;
    logic rx_ovf;
  } apc_events_t;
  // Control settings that one port hands to its datapath.
  typedef struct packed {
    logic rx_hec_check;
    logic tx_hec_insert;
    logic loop_timing;
    logic id_swap;
    logic [4:0] bus_addr;
    logic [1:0] rate;
  } apc_ctrl_t;
endpackage

// file: logic/apc_regs.sv
// Four-port status and control register bank of the cell physical layer.
// Behaviour
// (R1) Four register copies, 0x10 apart, from 0x03.
// (R2) Bit 6 clear: check received header HEC.
// (R3) Bit 5 clear: replace transmit fifth byte.
// (R4) Bits 4:3 set marker width 1/2/4/8.
// (R5) Bit 2 reads 1 when transmit buffer empty.
// (R6) Bit 1 reads 0 after a cell sent.
// (R7) Bit 0 reads 0 after a good cell received.
// (R8) Two bytes show the selected 16-bit counter.
// (R9) Selection bits: symbol, tx, rx, HEC errors.
// (R10) Received cell count skips failed header cells.
// (R11) Software sets one selection bit at most.
// (R12) Mask bit one blocks its interrupt source.
// (R13) Control one bit 7 resets port, self-clears.
// (R14) Port reset keeps rate and bus address.
// (R15) Control one bit 6 picks loop timing.
// (R16) Control one bit 5 enables identifier swap.
// (R17) Control one bits 4:0 hold bus address.
// (R18) Control two bits 7:6 set line rate.
// (R19) Interrupt status bits are sticky.
// (R20) Interrupt pin low while unmasked status set.
`timescale 1ns/1ps
`default_nettype none
module apc_regs (
  // Reference oscillator clock and asynchronous reset.
  input wire logic core_clk,
  input wire logic arst_n,
  // Register bus from the management side.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Received headers from the cell datapath.
  input wire logic [3:0] rx_hdr_valid,
  input wire logic [4*40-1:0] rx_hdr,
  // Transmit headers passing through for check byte insertion.
  input wire logic [3:0] tx_hdr_valid,
  input wire logic [4*40-1:0] tx_hdr_in,
  output logic [4*40-1:0] tx_hdr_out,
  output logic [3:0] tx_hdr_out_valid,
  // Per-port activity, buffer and timing inputs.
  input wire logic [3:0] tx_cell_sent,
  input wire logic [3:0] transmit_cell_buffer_empty,
  input wire logic [3:0] rx_marker_evt,
  input wire apc_pkg::apc_events_t [3:0] port_events,
  // Per-port outputs towards the datapath and the pin.
  output logic [3:0] rx_timing_marker_out,
  output logic [3:0] rx_hec_error,
  output apc_pkg::apc_ctrl_t [3:0] port_ctrl,
  output logic [3:0] port_reset,
  output logic int_n
);
  // Header check over four bytes, MSB first, with the coset added.
  function automatic logic [7:0] hec_calc(input logic [31:0] hdr);
    // Check register, cleared before each header.
    logic [7:0] crc;
    crc = 8'h00;
    // One step per header bit, first byte first.
    for (int i = 31; i >= 0; i--)
    begin
      if (crc[7] ^ hdr[i])
        crc = {crc[6:0], 1'b0} ^ apc_pkg::HEC_POLY;
      else
        crc = {crc[6:0], 1'b0};
    end
    return crc ^ apc_pkg::HEC_COSET;
  endfunction

  // Marker width code to a cycle count.
  function automatic logic [3:0] mark_len(input logic [1:0] code);
    case (code)
      2'h0: return apc_pkg::MARK_W0;
      2'h1: return apc_pkg::MARK_W1;
      2'h2: return apc_pkg::MARK_W2;
      default: return apc_pkg::MARK_W3;
    endcase
  endfunction

  // Upper address nibble picks the port, lower nibble the register.
  wire logic [3:0] addr_port = reg_addr[7:4];
  wire logic [3:0] addr_off = reg_addr[3:0];
  // Port-level read words, gathered for the read mux.
  logic [7:0] port_rdata [4];
  // Per-port unmasked pending interrupts.
  logic [3:0] port_irq;

  // One register set per port, picked by the upper address nibble.
  genvar p;
  generate
    for (p = 0; p < apc_pkg::NPORT; p++)
    begin : g_port
      // Register selects for this port.
      wire logic hit = (addr_port == 4'(p)); // (R1)
      wire logic wr_hec = reg_wr & hit & (addr_off == apc_pkg::OFF_HEC);
      wire logic rd_hec = reg_rd & hit & (addr_off == apc_pkg::OFF_HEC);
      wire logic wr_sel = reg_wr & hit & (addr_off == apc_pkg::OFF_CNT_SEL);
      wire logic wr_mask = reg_wr & hit & (addr_off == apc_pkg::OFF_MASK);
      wire logic wr_c1 = reg_wr & hit & (addr_off == apc_pkg::OFF_CTRL1);
      wire logic wr_c2 = reg_wr & hit & (addr_off == apc_pkg::OFF_CTRL2);
      wire logic wr_irq = reg_wr & hit & (addr_off == apc_pkg::OFF_IRQ_STAT);

      // Software-visible state of the port.
      // Receive header check disabled.
      logic rx_hec_off;
      // Transmit check byte insertion disabled.
      logic tx_hec_off;
      // Marker width code.
      logic [1:0] mark_code;
      // No cell sent since the last read.
      logic tx_idle;
      // No good cell received since the last read.
      logic rx_idle;
      // Counter selection, one bit per counter.
      logic [3:0] cnt_sel;
      // Interrupt mask, one bit per source.
      logic [5:0] mask;
      // Transmit clock from the recovered clock.
      logic loop_timing;
      // Identifier swap on received cells.
      logic id_swap;
      // Cell bus address of the port.
      logic [4:0] bus_addr;
      // Line rate and drive code.
      logic [1:0] rate;
      // Sticky interrupt status.
      logic [5:0] irq_stat;
      // One-cycle port reset pulse.
      logic soft_rst;
      // Symbol error count.
      logic [15:0] cnt_sym;
      // Transmitted cell count.
      logic [15:0] cnt_txc;
      // Good received cell count.
      logic [15:0] cnt_rxc;
      // Failed header count.
      logic [15:0] cnt_hec;
      // Remaining marker cycles.
      logic [3:0] mark_cnt;

      // Received header check result; a disabled check never fails.
      wire logic [39:0] rh = rx_hdr[p*40 +: 40];
      wire logic hec_bad = rx_hdr_valid[p] & ~rx_hec_off
                           & (hec_calc(rh[39:8]) != rh[7:0]); // (R2)
      wire logic rx_good = rx_hdr_valid[p] & ~hec_bad;
      // Transmit header with the fifth byte replaced unless disabled.
      wire logic [39:0] th = tx_hdr_in[p*40 +: 40];
      wire logic [7:0] tx_hec = tx_hec_off ? th[7:0] : hec_calc(th[39:8]); // (R3)
      // New events in the sticky layout.
      wire apc_pkg::apc_events_t ev = port_events[p];
      wire logic [5:0] irq_set = {hec_bad, ev.short_cell, ev.tx_parity,
                                  ev.sig_change, ev.symbol_err, ev.rx_ovf};
      // Selected counter value.
      wire logic [15:0] cnt_view = cnt_sel[apc_pkg::SEL_SYM] ? cnt_sym :
                                   cnt_sel[apc_pkg::SEL_TXC] ? cnt_txc :
                                   cnt_sel[apc_pkg::SEL_RXC] ? cnt_rxc :
                                   cnt_sel[apc_pkg::SEL_HEC] ? cnt_hec :
                                   apc_pkg::RST_CNT; // (R9)
      // Software port reset of the port's clearable state; arst_n acts on its own.
      wire logic clr = soft_rst;

      // Control bits and self-clearing port reset.
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          rx_hec_off <= 1'b0;
          tx_hec_off <= 1'b0;
          mark_code <= apc_pkg::RST_MARK;
          cnt_sel <= 4'h0;
          mask <= apc_pkg::RST_MASK;
          loop_timing <= 1'b0;
          id_swap <= 1'b0;
          soft_rst <= 1'b0;
        end
        else
        begin
          soft_rst <= wr_c1 & reg_wdata[apc_pkg::B_PORT_RST]; // (R13)
          // The port reset wins over a write in the same cycle.
          if (clr)
          begin
            rx_hec_off <= 1'b0;
            tx_hec_off <= 1'b0;
            mark_code <= apc_pkg::RST_MARK;
            cnt_sel <= 4'h0;
            mask <= apc_pkg::RST_MASK;
            loop_timing <= 1'b0;
            id_swap <= 1'b0;
          end
          else
          begin
            // Each write reaches only its own register.
            if (wr_hec)
            begin
              rx_hec_off <= reg_wdata[apc_pkg::B_RX_HEC_OFF];
              tx_hec_off <= reg_wdata[apc_pkg::B_TX_HEC_OFF];
              mark_code <= reg_wdata[apc_pkg::B_MARK_HI:apc_pkg::B_MARK_LO]; // (R4)
            end
            if (wr_sel)
              cnt_sel <= reg_wdata[3:0]; // (R9) (R11)
            if (wr_mask)
              mask <= reg_wdata[5:0]; // (R12)
            if (wr_c1)
            begin
              loop_timing <= reg_wdata[apc_pkg::B_LOOP_TIME]; // (R15)
              id_swap <= reg_wdata[apc_pkg::B_ID_SWAP]; // (R16)
            end
          end
        end
      end

      // Bus address and line rate survive the port reset.
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          bus_addr <= 5'(p); // (R17)
          rate <= apc_pkg::RST_RATE;
        end
        else
        begin
          // No port reset term here, so these fields persist.
          if (wr_c1)
            bus_addr <= reg_wdata[apc_pkg::B_ADDR_HI:0]; // (R17) (R14)
          if (wr_c2)
            rate <= reg_wdata[apc_pkg::B_RATE_HI:apc_pkg::B_RATE_LO]; // (R18) (R14)
        end
      end

      // Activity flags drop on a cell and return high once software reads them.
      // An event in the read cycle wins, so no cell goes unreported.
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          tx_idle <= 1'b1;
          rx_idle <= 1'b1;
        end
        // The port reset returns both flags to idle.
        else if (clr)
        begin
          tx_idle <= 1'b1;
          rx_idle <= 1'b1;
        end
        else
        begin
          tx_idle <= ~tx_cell_sent[p] & (tx_idle | rd_hec); // (R6)
          rx_idle <= ~rx_good & (rx_idle | rd_hec); // (R7)
        end
      end

      // Sticky interrupt status, write one to clear; a new event wins.
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
          irq_stat <= 6'h00;
        else if (clr)
          irq_stat <= 6'h00;
        // Write one to clear; an event in that cycle stays set.
        else if (wr_irq)
          irq_stat <= (irq_stat & ~reg_wdata[5:0]) | irq_set; // (R19)
        else
          irq_stat <= irq_stat | irq_set; // (R19)
      end

      // Statistics counters, wrapping at 16 bits.
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          cnt_sym <= apc_pkg::RST_CNT;
          cnt_txc <= apc_pkg::RST_CNT;
          cnt_rxc <= apc_pkg::RST_CNT;
          cnt_hec <= apc_pkg::RST_CNT;
        end
        else if (clr)
        begin
          cnt_sym <= apc_pkg::RST_CNT;
          cnt_txc <= apc_pkg::RST_CNT;
          cnt_rxc <= apc_pkg::RST_CNT;
          cnt_hec <= apc_pkg::RST_CNT;
        end
        // Each counter steps by at most one per cycle.
        else
        begin
          cnt_sym <= cnt_sym + 16'(ev.symbol_err);
          cnt_txc <= cnt_txc + 16'(tx_cell_sent[p]);
          cnt_rxc <= cnt_rxc + 16'(rx_good); // (R10)
          cnt_hec <= cnt_hec + 16'(hec_bad);
        end
      end

      // Timing marker stretcher; a new marker restarts the count.
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
          mark_cnt <= 4'h0;
        else if (clr)
          mark_cnt <= 4'h0;
        // A new marker loads the full width.
        else if (rx_marker_evt[p])
          mark_cnt <= mark_len(mark_code); // (R4)
        // Count down to zero, then hold.
        else if (mark_cnt != 4'h0)
          mark_cnt <= mark_cnt - 4'h1;
      end

      // Datapath-facing outputs, all registered.
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          rx_timing_marker_out[p] <= 1'b0;
          rx_hec_error[p] <= 1'b0;
          tx_hdr_out[p*40 +: 40] <= 40'h0;
          tx_hdr_out_valid[p] <= 1'b0;
          port_reset[p] <= 1'b0;
          port_ctrl[p] <= '0;
        end
        else
        begin
          // Active for exactly the selected number of cycles.
          rx_timing_marker_out[p] <= rx_marker_evt[p] | (mark_cnt > 4'h1); // (R4)
          rx_hec_error[p] <= hec_bad; // (R2)
          tx_hdr_out[p*40 +: 40] <= {th[39:8], tx_hec}; // (R3)
          tx_hdr_out_valid[p] <= tx_hdr_valid[p];
          port_reset[p] <= soft_rst; // (R13)
          port_ctrl[p] <= '{rx_hec_check: ~rx_hec_off, tx_hec_insert: ~tx_hec_off,
                            loop_timing: loop_timing, id_swap: id_swap,
                            bus_addr: bus_addr, rate: rate};
        end
      end

      // Read word of this port; write-only selection reads zero.
      wire logic [7:0] hec_word = {1'b0, rx_hec_off, tx_hec_off, mark_code,
                                   transmit_cell_buffer_empty[p], // (R5)
                                   tx_idle, rx_idle};
      assign port_rdata[p] =
        (addr_off == apc_pkg::OFF_HEC) ? hec_word :
        (addr_off == apc_pkg::OFF_CNT_LO) ? cnt_view[7:0] : // (R8)
        (addr_off == apc_pkg::OFF_CNT_HI) ? cnt_view[15:8] : // (R8)
        (addr_off == apc_pkg::OFF_MASK) ? {2'h0, mask} :
        (addr_off == apc_pkg::OFF_CTRL1) ? {1'b0, loop_timing, id_swap, bus_addr} :
        (addr_off == apc_pkg::OFF_CTRL2) ? {rate, 6'h00} :
        (addr_off == apc_pkg::OFF_IRQ_STAT) ? {2'h0, irq_stat} : 8'h00;
      // The port requests the pin for any unmasked status bit.
      assign port_irq[p] = |(irq_stat & ~mask); // (R12)
    end
  endgenerate

  // Port select for the read mux; addresses above port 3 read zero.
  wire logic port_ok = (addr_port < 4'(apc_pkg::NPORT)); // (R1)
  wire logic [7:0] next_rdata = port_ok ? port_rdata[addr_port[1:0]] : 8'h00;

  // Read data are registered and stand only in the cycle after the strobe.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    // Outside a read the bus shows zero, so stale data never stand.
    else
      reg_rdata <= 8'h00;
  end

  // Shared active-low interrupt pin, registered to keep the output glitch free.
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      int_n <= 1'b1;
    else
      int_n <= ~|port_irq; // (R20)
  end
endmodule
`default_nettype wire

// file: testbench/apc_regs_properties.sv
// Concurrent checks on the ports of the register bank.
`timescale 1ns/1ps
`default_nettype none
module apc_regs_properties (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [3:0] rx_hdr_valid,
  input wire logic [3:0] rx_hec_error,
  input wire logic [3:0] tx_hdr_valid,
  input wire logic [4*40-1:0] tx_hdr_in,
  input wire logic [4*40-1:0] tx_hdr_out,
  input wire logic [3:0] tx_hdr_out_valid,
  input wire logic [3:0] rx_marker_evt,
  input wire logic [3:0] rx_timing_marker_out,
  input wire apc_pkg::apc_ctrl_t [3:0] port_ctrl,
  input wire logic [3:0] port_reset
);
  // One clock domain, so clock and reset are given once for all checks.
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  a_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (reg_rd && reg_addr[7:4] > 4'h3 |=> reg_rdata == 8'h00)
    else $error("unmapped port returned data");
  a_select_wo: assert property (reg_rd && reg_addr[3:0] == 4'h6 |=> reg_rdata == 8'h00)
    else $error("counter selection readable");
  a_hec_err_cause: assert property (rx_hec_error[0] |-> $past(rx_hdr_valid[0]))
    else $error("header error without a received header");
  a_tx_valid_follow: assert property (tx_hdr_valid[0] |=> tx_hdr_out_valid[0])
    else $error("transmit header not passed on");
  a_tx_head_copy: assert property (tx_hdr_out_valid[0] |-> tx_hdr_out[39:8] == $past(tx_hdr_in[39:8]))
    else $error("transmit header bytes altered");
  a_marker_start: assert property (rx_marker_evt[0] |=> rx_timing_marker_out[0])
    else $error("marker did not start");
  a_marker_bound: assert property (!rx_marker_evt[0] [*8] |=> !rx_timing_marker_out[0])
    else $error("marker longer than eight cycles");
  a_reset_single: assert property (port_reset[3] |=> !port_reset[3])
    else $error("port reset longer than one cycle");
  a_reset_cause: assert property (port_reset[3] |-> $past(reg_wr, 2) && $past(reg_addr, 2) == 8'h38 && $past(reg_wdata[7], 2))
    else $error("port reset without reset write");
  a_addr_follow: assert property (reg_wr && reg_addr == 8'h38 |-> ##2 port_ctrl[3].bus_addr == $past(reg_wdata[4:0], 2))
    else $error("bus address not exported");
  a_rate_follow: assert property (reg_wr && reg_addr == 8'h39 |-> ##2 port_ctrl[3].rate == $past(reg_wdata[7:6], 2))
    else $error("line rate not exported");
endmodule
bind apc_regs apc_regs_properties apc_regs_properties_i (.core_clk(core_clk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .rx_hdr_valid(rx_hdr_valid), .rx_hec_error(rx_hec_error),
  .tx_hdr_valid(tx_hdr_valid), .tx_hdr_in(tx_hdr_in), .tx_hdr_out(tx_hdr_out),
  .tx_hdr_out_valid(tx_hdr_out_valid), .rx_marker_evt(rx_marker_evt),
  .rx_timing_marker_out(rx_timing_marker_out), .port_ctrl(port_ctrl), .port_reset(port_reset));
`default_nettype wire

// file: testbench/apc_regs_test.sv
// Self-checking bench for the four-port register bank.
`timescale 1ns/1ps
`default_nettype none
module apc_regs_test;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] rx_hdr_valid = 4'h0;
  logic [159:0] rx_hdr = 160'h0;
  logic [3:0] tx_hdr_valid = 4'h0;
  logic [159:0] tx_hdr_in = 160'h0;
  logic [159:0] tx_hdr_out;
  logic [3:0] tx_hdr_out_valid;
  logic [3:0] tx_cell_sent = 4'h0;
  logic [3:0] tx_empty = 4'hf;
  logic [3:0] rx_marker_evt = 4'h0;
  apc_pkg::apc_events_t [3:0] port_events = 20'h0;
  logic [3:0] rx_timing_marker_out;
  logic [3:0] rx_hec_error;
  logic [3:0] port_reset;
  apc_pkg::apc_ctrl_t [3:0] port_ctrl;
  logic int_n;
  int fail_count = 0;
  int comparisons = 0;
  // Free-running 25 MHz clock.
  always #20 core_clk = ~core_clk;
  apc_regs apc_regs_i (.core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .rx_hdr_valid(rx_hdr_valid), .rx_hdr(rx_hdr), .tx_hdr_valid(tx_hdr_valid),
    .tx_hdr_in(tx_hdr_in), .tx_hdr_out(tx_hdr_out), .tx_hdr_out_valid(tx_hdr_out_valid),
    .tx_cell_sent(tx_cell_sent), .transmit_cell_buffer_empty(tx_empty),
    .rx_marker_evt(rx_marker_evt), .port_events(port_events),
    .rx_timing_marker_out(rx_timing_marker_out), .rx_hec_error(rx_hec_error),
    .port_ctrl(port_ctrl), .port_reset(port_reset), .int_n(int_n));
  // Prints the counts and the verdict, then stops the run.
  task automatic conclude();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Case equality, so an unknown never counts as a match.
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Header check code, computed here independently of the design.
  function automatic logic [7:0] hec(input logic [31:0] h);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
    return c ^ 8'h55;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Read data is only valid in the cycle after the strobe, so it is taken there.
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  // Reads both counter bytes with no other access in between.
  task automatic cnt16(input logic [7:0] base, input logic [15:0] exp);
    logic [7:0] lo;
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= base;
    @(posedge core_clk);
    reg_addr <= base + 8'h01;
    #1 lo = reg_rdata;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 check({reg_rdata, lo}, exp);
  endtask
  task automatic rxcell(input logic [39:0] h, input logic err);
    @(posedge core_clk);
    rx_hdr[39:0] <= h;
    rx_hdr_valid[0] <= 1'b1;
    @(posedge core_clk);
    rx_hdr_valid[0] <= 1'b0;
    #1 check(rx_hec_error[0], err);
  endtask
  task automatic txcell(input logic [39:0] h, input logic [39:0] exp);
    @(posedge core_clk);
    tx_hdr_in[39:0] <= h;
    tx_hdr_valid[0] <= 1'b1;
    @(posedge core_clk);
    tx_hdr_valid[0] <= 1'b0;
    #1 check(tx_hdr_out_valid[0], 1'b1);
    check(tx_hdr_out[39:24], exp[39:24]);
    check(tx_hdr_out[23:8], exp[23:8]);
    check(tx_hdr_out[7:0], exp[7:0]);
  endtask
  // Reset values of every port, plus an unmapped port and offset.
  task automatic t_reset_map();
    for (int p = 0; p < 4; p++)
    begin
      rdc({p[3:0], 4'h3}, 8'h07);
      cnt16({p[3:0], 4'h4}, 16'h0000);
      rdc({p[3:0], 4'h6}, 8'h00);
      rdc({p[3:0], 4'h7}, 8'h00);
      rdc({p[3:0], 4'h8}, 8'(p));
      rdc({p[3:0], 4'h9}, 8'h00);
      check(port_ctrl[p].loop_timing, 1'b0);
    end
    rdc(8'h43, 8'h00);
    rdc(8'h01, 8'h00);
  endtask
  // Writable fields take all ones; read-only and reserved bits do not.
  task automatic t_rw();
    wr(8'h27, 8'hff);
    rdc(8'h27, 8'h3f);
    wr(8'h23, 8'hff);
    rdc(8'h23, 8'h7f);
    check(port_ctrl[2].rx_hec_check, 1'b0);
    check(port_ctrl[2].tx_hec_insert, 1'b0);
    wr(8'h28, 8'h7f);
    rdc(8'h28, 8'h7f);
    check(port_ctrl[2].id_swap, 1'b1);
    wr(8'h29, 8'hff);
    rdc(8'h29, 8'hc0);
  endtask
  // Good, failing and unchecked headers on port 0, with counters and activity.
  task automatic t_rx();
    rxcell({32'h12345678, hec(32'h12345678)}, 1'b0);
    rdc(8'h03, 8'h06);
    rxcell({32'h12345678, hec(32'h12345678) ^ 8'h01}, 1'b1);
    rdc(8'h03, 8'h07);
    check(int_n, 1'b0);
    rdc(8'h0a, 8'h20);
    wr(8'h06, 8'h02);
    cnt16(8'h04, 16'h0001);
    wr(8'h06, 8'h01);
    cnt16(8'h04, 16'h0001);
    wr(8'h0a, 8'h20);
    rdc(8'h0a, 8'h00);
    check(int_n, 1'b1);
    wr(8'h03, 8'h40);
    rxcell({32'h0a0b0c0d, 8'h00}, 1'b0);
    wr(8'h06, 8'h02);
    cnt16(8'h04, 16'h0002);
  endtask
  // Transmit byte five replacement and the transmit status bits.
  task automatic t_tx();
    wr(8'h03, 8'h00);
    txcell({32'hc0ffee01, 8'ha5}, {32'hc0ffee01, hec(32'hc0ffee01)});
    wr(8'h03, 8'h20);
    txcell({32'hc0ffee01, 8'ha5}, {32'hc0ffee01, 8'ha5});
    @(posedge core_clk);
    tx_cell_sent[0] <= 1'b1;
    tx_empty[0] <= 1'b0;
    @(posedge core_clk);
    tx_cell_sent[0] <= 1'b0;
    rdc(8'h03, 8'h20);
    @(posedge core_clk);
    tx_empty[0] <= 1'b1;
    rdc(8'h03, 8'h27);
    wr(8'h06, 8'h04);
    cnt16(8'h04, 16'h0001);
  endtask
  // Each width code stretches the marker to its cycle count.
  task automatic t_marker();
    int n;
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h03, 8'(c << 3));
      n = 0;
      @(posedge core_clk);
      rx_marker_evt[0] <= 1'b1;
      @(posedge core_clk);
      rx_marker_evt[0] <= 1'b0;
      repeat (12)
      begin
        #1 n += int'(rx_timing_marker_out[0]);
        @(posedge core_clk);
      end
      check(16'(n), 16'(1 << c));
    end
  endtask
  // Every datapath event is held masked, then shown on the pin, then cleared.
  task automatic t_irq();
    wr(8'h17, 8'h3f);
    for (int i = 0; i < 5; i++)
    begin
      @(posedge core_clk);
      port_events[1] <= apc_pkg::apc_events_t'(5'h01 << i);
      @(posedge core_clk);
      port_events[1] <= 5'h00;
      repeat (3) @(posedge core_clk);
      #1 check(int_n, 1'b1);
      rdc(8'h1a, 8'(1 << i));
      wr(8'h17, 8'h3f & ~8'(1 << i));
      for (int k = 0; k < 6 && int_n !== 1'b0; k++)
        @(posedge core_clk);
      #1 check(int_n, 1'b0);
      wr(8'h1a, 8'(1 << i));
      wr(8'h17, 8'h3f);
      rdc(8'h1a, 8'h00);
      check(int_n, 1'b1);
    end
    wr(8'h16, 8'h08);
    cnt16(8'h14, 16'h0001);
  endtask
  // The port reset keeps the rate and address but clears the other settings.
  task automatic t_soft();
    wr(8'h39, 8'h80);
    wr(8'h37, 8'h15);
    wr(8'h38, 8'h7e);
    wr(8'h38, 8'h9e);
    repeat (3) @(posedge core_clk);
    rdc(8'h38, 8'h1e);
    rdc(8'h39, 8'h80);
    rdc(8'h37, 8'h00);
    check(port_ctrl[3].bus_addr, 5'h1e);
  endtask
  // A hang anywhere is cut short here.
  initial
  begin
    repeat (50000) @(posedge core_clk);
    fail_count++;
    conclude();
  end
  initial
  begin
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset_map();
    t_rw();
    t_rx();
    t_tx();
    t_marker();
    t_irq();
    t_soft();
    conclude();
  end
endmodule
`default_nettype wire
